// *** logic/dtp_pkg.sv ***
// Shared constants, types and register map of the dual trigger ports
package dtp_pkg;

    // Register byte offsets, one aligned 32-bit word each
    localparam logic [5:0] OFF_CTRL_A      = 6'h00;
    localparam logic [5:0] OFF_CTRL_B      = 6'h04;
    localparam logic [5:0] OFF_DOUT        = 6'h08;
    localparam logic [5:0] OFF_STATUS      = 6'h0C;
    localparam logic [5:0] OFF_FWD_FIRST   = 6'h10;
    localparam logic [5:0] OFF_FWD_SPACING = 6'h14;
    localparam logic [5:0] OFF_FWD_COUNT   = 6'h18;
    localparam logic [5:0] OFF_REV_FIRST   = 6'h1C;
    localparam logic [5:0] OFF_REV_SPACING = 6'h20;
    localparam logic [5:0] OFF_REV_COUNT   = 6'h24;
    localparam logic [5:0] OFF_WIDTH       = 6'h28;
    localparam logic [5:0] OFF_REPEAT      = 6'h2C;
    localparam logic [5:0] OFF_REL_DIST    = 6'h30;
    localparam logic [5:0] OFF_ABS_POS     = 6'h34;
    localparam int         NREG            = 14;

    // Writable bits per register; the rest read as zero, except the live status bits
    localparam logic [31:0] REG_MASK [NREG] = '{
        32'h0000_001F, 32'h0000_001F, 32'h0000_0003, 32'h0000_0000,
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF, 32'hFFFF_FFFF,
        32'hFFFF_FFFF, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF,
        32'hFFFF_FFFF, 32'hFFFF_FFFF};
    localparam logic [31:0] REG_RST [NREG] = '{
        32'h0000_0010, 32'h0000_0010, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001,
        32'h0000_0000, 32'h0000_0000};

    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_W   = 4;
    localparam int CTRL_POL_BIT  = 4;

    // Status register fields
    localparam int STAT_LVL_A    = 0;
    localparam int STAT_LVL_B    = 1;
    localparam int STAT_BUSY     = 2;
    localparam int STAT_CONFLICT = 3;

    localparam int CNT_W   = 16;
    localparam int PW_CNT_W = 24;

    // Pulse width is programmed in microseconds
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int WIDTH_UNIT_NS  = 1000;
    localparam int WIDTH_UNIT_CYC = (WIDTH_UNIT_NS * 1000) / CLK_PERIOD_PS;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        DTP_DISABLED  = 4'h0,
        DTP_DIG_IN    = 4'h1,
        DTP_IN_REL    = 4'h2,
        DTP_IN_ABS    = 4'h3,
        DTP_IN_HOME   = 4'h4,
        DTP_DIG_OUT   = 4'h5,
        DTP_OUT_MOVE  = 4'h6,
        DTP_OUT_MAXV  = 4'h7,
        DTP_STEP_FWD  = 4'h8,
        DTP_STEP_REV  = 4'h9,
        DTP_STEP_BOTH = 4'hA
    } dtp_mode_t;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_FWD,
        SEQ_REV,
        SEQ_DONE
    } dtp_seq_t;

    // One-cycle start requests to the motion controller
    typedef struct packed {
        logic rel;
        logic abs_mv;
        logic home;
    } dtp_move_cmd_t;

    // Drive of one two-way pin
    typedef struct packed {
        logic o;
        logic oe;
    } dtp_pin_t;

endpackage

// *** logic/dtp_sync2.sv ***
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module dtp_sync2 #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r   <= '1;
            sync_out <= '1;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // dtp_sync2

// *** logic/dtp_pulse_timer.sv ***
// Retriggerable pulse of programmable length in clock cycles
`timescale 1ns/1ps
module dtp_pulse_timer (
    // Clock and reset
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // Control
    input  wire logic                         fire,
    input  wire logic [dtp_pkg::PW_CNT_W-1:0] width_cyc,
    // Pulse
    output logic                              active
);
    logic [dtp_pkg::PW_CNT_W-1:0] left_r;

    // Width zero still gives one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left_r <= '0;
            active <= 1'b0;
        end else if (fire) begin
            left_r <= (width_cyc == '0) ? dtp_pkg::PW_CNT_W'(1) : width_cyc;
            active <= 1'b1;
        end else if (left_r > dtp_pkg::PW_CNT_W'(1)) begin
            left_r <= left_r - dtp_pkg::PW_CNT_W'(1);
        end else begin
            left_r <= '0;
            active <= 1'b0;
        end
    end
endmodule // dtp_pulse_timer

// *** logic/dtp_trigger_ports.sv ***
// Two trigger ports with position compare and AXI4-Lite registers
//
// What this block does
// - Two ports, each input or output, polarity chosen high or low.
// - Move-trigger inputs act on inactive-to-active transitions only.
// - A held active level starts one move; must go inactive first.
// - Disabled port ignores its input and drives nothing.
// - General input level is only reported in status, no motion.
// - Relative or absolute trigger starts move by distance or to target.
// - Home trigger edge starts a homing move.
// - General output drives the level software writes.
// - Motion output is active while the stage moves.
// - Max-velocity output is active while at maximum velocity.
// - Step modes pulse forward only, backward only, or both ways.
// - Only one port may use a step mode at a time.
// - Count pulses of set width at start plus multiples of spacing.
// - Forward and reverse each have own start, spacing and count.
// - Repeat count repeats the whole step sequence that many times.
// - Match pulse within 1 us, from dedicated compare logic.
// - Active high means high level and rising edges; low the inverse.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module dtp_trigger_ports (
    // Clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // AXI4-Lite write address and data
    input  wire logic [5:0]           awaddr,
    input  wire logic [2:0]           awprot,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    // AXI4-Lite write response
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    // AXI4-Lite read
    input  wire logic [5:0]           araddr,
    input  wire logic [2:0]           arprot,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready,
    // Trigger pins
    input  wire logic                 event_port_a_in,
    output logic                      event_port_a_out,
    output logic                      event_port_a_oe,
    input  wire logic                 event_port_b_in,
    output logic                      event_port_b_out,
    output logic                      event_port_b_oe,
    // Motion controller
    input  wire logic [31:0]          act_pos,
    input  wire logic                 in_motion,
    input  wire logic                 at_max_vel,
    output dtp_pkg::dtp_move_cmd_t    move_cmd,
    output logic [31:0]               rel_distance,
    output logic [31:0]               abs_target
);
    logic [31:0]                  regs_r [dtp_pkg::NREG];
    logic                         aw_held_r;
    logic [5:0]                   awaddr_r;
    logic                         w_held_r;
    logic [31:0]                  wdata_r;
    logic [3:0]                   wstrb_r;
    logic                         do_wr;
    logic [3:0]                   wr_idx;
    logic [3:0]                   rd_idx;
    logic [31:0]                  status;
    logic [1:0]                   pin_raw;
    logic [1:0]                   pin_sync;
    logic [1:0]                   act_lvl;
    logic [1:0]                   act_prev_r;
    logic [1:0]                   edge_hit;
    dtp_pkg::dtp_mode_t           mode [2];
    logic [1:0]                   pol_high;
    dtp_pkg::dtp_pin_t            drive [2];
    logic [1:0]                   step_mode;
    logic                         step_sel_r;
    logic                         step_any;
    dtp_pkg::dtp_mode_t           step_kind;
    dtp_pkg::dtp_seq_t            seq_r;
    logic [31:0]                  prev_pos_r;
    logic signed [31:0]           fwd_tgt_r;
    logic signed [31:0]           rev_tgt_r;
    logic [dtp_pkg::CNT_W-1:0]    fwd_left_r;
    logic [dtp_pkg::CNT_W-1:0]    rev_left_r;
    logic [dtp_pkg::CNT_W-1:0]    cycles_r;
    logic                         fwd_hit;
    logic                         rev_hit;
    logic                         rearm;
    logic                         step_pulse;
    logic [dtp_pkg::PW_CNT_W-1:0] width_cyc;
    logic [dtp_pkg::CNT_W-1:0]    fwd_cnt;
    logic [dtp_pkg::CNT_W-1:0]    rev_cnt;
    logic [dtp_pkg::CNT_W-1:0]    rep_cnt;

    // Zero counts behave as one
    function automatic logic [dtp_pkg::CNT_W-1:0] at_least1(
        input logic [31:0] v);
        logic [dtp_pkg::CNT_W-1:0] c;
        c = v[dtp_pkg::CNT_W-1:0];
        return (c == '0) ? dtp_pkg::CNT_W'(1) : c;
    endfunction

    // AXI4-Lite slave
    assign awready = !aw_held_r;
    assign wready  = !w_held_r;
    assign do_wr   = aw_held_r && w_held_r && !bvalid;
    assign wr_idx  = awaddr_r[5:2];
    assign rd_idx  = araddr[5:2];
    assign arready = !rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r  <= '0;
        end else if (awvalid && awready) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= awaddr;
        end else if (do_wr) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else if (wvalid && wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= wdata;
            wstrb_r  <= wstrb;
        end else if (do_wr) begin
            w_held_r <= 1'b0;
        end
    end

    // Status writes are ignored; addresses past the map get SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= dtp_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            bresp  <= (32'(wr_idx) < dtp_pkg::NREG) ? dtp_pkg::RESP_OKAY
                                                    : dtp_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    generate
        for (genvar i = 0; i < dtp_pkg::NREG; i++) begin : g_reg
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    regs_r[i] <= dtp_pkg::REG_RST[i];
                end else if (do_wr && wr_idx == 4'(i)) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wstrb_r[b]) begin
                            regs_r[i][8*b +: 8] <= wdata_r[8*b +: 8]
                                & dtp_pkg::REG_MASK[i][8*b +: 8];
                        end
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= dtp_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            if (araddr == dtp_pkg::OFF_STATUS) begin
                rdata <= status;
                rresp <= dtp_pkg::RESP_OKAY;
            end else if (32'(rd_idx) < dtp_pkg::NREG) begin
                rdata <= regs_r[rd_idx];
                rresp <= dtp_pkg::RESP_OKAY;
            end else begin
                rdata <= '0;
                rresp <= dtp_pkg::RESP_SLVERR;
            end
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Configuration decode
    assign mode[0] = dtp_pkg::dtp_mode_t'(regs_r[dtp_pkg::OFF_CTRL_A[5:2]]
        [dtp_pkg::CTRL_MODE_LSB +: dtp_pkg::CTRL_MODE_W]);
    assign mode[1] = dtp_pkg::dtp_mode_t'(regs_r[dtp_pkg::OFF_CTRL_B[5:2]]
        [dtp_pkg::CTRL_MODE_LSB +: dtp_pkg::CTRL_MODE_W]);
    assign pol_high[0] =
        regs_r[dtp_pkg::OFF_CTRL_A[5:2]][dtp_pkg::CTRL_POL_BIT];
    assign pol_high[1] =
        regs_r[dtp_pkg::OFF_CTRL_B[5:2]][dtp_pkg::CTRL_POL_BIT];

    assign width_cyc = dtp_pkg::PW_CNT_W'(
        regs_r[dtp_pkg::OFF_WIDTH[5:2]][dtp_pkg::CNT_W-1:0]
        * dtp_pkg::WIDTH_UNIT_CYC);
    assign fwd_cnt = at_least1(regs_r[dtp_pkg::OFF_FWD_COUNT[5:2]]);
    assign rev_cnt = at_least1(regs_r[dtp_pkg::OFF_REV_COUNT[5:2]]);
    assign rep_cnt = at_least1(regs_r[dtp_pkg::OFF_REPEAT[5:2]]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rel_distance <= '0;
            abs_target   <= '0;
        end else begin
            rel_distance <= regs_r[dtp_pkg::OFF_REL_DIST[5:2]];
            abs_target   <= regs_r[dtp_pkg::OFF_ABS_POS[5:2]];
        end
    end

    // Input side
    assign pin_raw = {event_port_b_in, event_port_a_in};

    dtp_sync2 #(
        .W        (2)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pin_raw),
        .sync_out (pin_sync)
    );

    generate
        for (genvar p = 0; p < 2; p++) begin : g_in
            assign act_lvl[p]   = pin_sync[p] ~^ pol_high[p];
            assign step_mode[p] = mode[p] inside {dtp_pkg::DTP_STEP_FWD,
                dtp_pkg::DTP_STEP_REV, dtp_pkg::DTP_STEP_BOTH};
            // Only a fresh inactive-to-active change counts
            assign edge_hit[p]  = act_lvl[p] && !act_prev_r[p];
        end
    endgenerate

    // Starts as active so a pin already active at reset does not fire
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_prev_r <= 2'h3;
        end else begin
            act_prev_r <= act_lvl;
        end
    end

    // Disabled and digital-input ports never reach the move requests
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            move_cmd <= '0;
        end else begin
            move_cmd.rel <=
                (edge_hit[0] && mode[0] == dtp_pkg::DTP_IN_REL) ||
                (edge_hit[1] && mode[1] == dtp_pkg::DTP_IN_REL);
            move_cmd.abs_mv <=
                (edge_hit[0] && mode[0] == dtp_pkg::DTP_IN_ABS) ||
                (edge_hit[1] && mode[1] == dtp_pkg::DTP_IN_ABS);
            move_cmd.home <=
                (edge_hit[0] && mode[0] == dtp_pkg::DTP_IN_HOME) ||
                (edge_hit[1] && mode[1] == dtp_pkg::DTP_IN_HOME);
        end
    end

    // Position compare
    // Port A wins when both ask for step mode; one parameter set only
    assign step_any  = step_mode[0] || step_mode[1];
    assign step_kind = step_mode[0] ? mode[0] : mode[1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_sel_r <= 1'b0;
        end else begin
            step_sel_r <= !step_mode[0];
        end
    end

    // Any write or a change of owner restarts the sequence
    assign rearm = do_wr || !step_any ||
                   (step_sel_r != !step_mode[0]);

    localparam dtp_pkg::dtp_seq_t SEQ_FWD_C = dtp_pkg::SEQ_FWD;
    localparam dtp_pkg::dtp_seq_t SEQ_REV_C = dtp_pkg::SEQ_REV;

    // Crossing test copes with positions that skip past the target
    assign fwd_hit = (seq_r == SEQ_FWD_C) &&
        ($signed(prev_pos_r) < fwd_tgt_r) &&
        ($signed(act_pos) >= fwd_tgt_r);
    assign rev_hit = (seq_r == SEQ_REV_C) &&
        ($signed(prev_pos_r) > rev_tgt_r) &&
        ($signed(act_pos) <= rev_tgt_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_pos_r <= '0;
        end else begin
            prev_pos_r <= act_pos;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || rearm) begin
            seq_r      <= dtp_pkg::SEQ_IDLE;
            fwd_tgt_r  <= '0;
            rev_tgt_r  <= '0;
            fwd_left_r <= '0;
            rev_left_r <= '0;
            cycles_r   <= '0;
        end else begin
            unique case (seq_r)
                dtp_pkg::SEQ_IDLE: begin
                    fwd_tgt_r  <= $signed(
                        regs_r[dtp_pkg::OFF_FWD_FIRST[5:2]]);
                    rev_tgt_r  <= $signed(
                        regs_r[dtp_pkg::OFF_REV_FIRST[5:2]]);
                    fwd_left_r <= fwd_cnt;
                    rev_left_r <= rev_cnt;
                    seq_r <= (step_kind == dtp_pkg::DTP_STEP_REV)
                        ? dtp_pkg::SEQ_REV : dtp_pkg::SEQ_FWD;
                end
                dtp_pkg::SEQ_FWD: begin
                    if (fwd_hit) begin
                        fwd_tgt_r  <= fwd_tgt_r + $signed(
                            regs_r[dtp_pkg::OFF_FWD_SPACING[5:2]]);
                        fwd_left_r <= fwd_left_r - dtp_pkg::CNT_W'(1);
                        if (fwd_left_r == dtp_pkg::CNT_W'(1)) begin
                            if (step_kind == dtp_pkg::DTP_STEP_BOTH) begin
                                seq_r <= dtp_pkg::SEQ_REV;
                            end else if (cycles_r + dtp_pkg::CNT_W'(1)
                                         >= rep_cnt) begin
                                seq_r <= dtp_pkg::SEQ_DONE;
                            end else begin
                                cycles_r <= cycles_r + dtp_pkg::CNT_W'(1);
                                seq_r    <= dtp_pkg::SEQ_IDLE;
                            end
                        end
                    end
                end
                dtp_pkg::SEQ_REV: begin
                    if (rev_hit) begin
                        rev_tgt_r  <= rev_tgt_r - $signed(
                            regs_r[dtp_pkg::OFF_REV_SPACING[5:2]]);
                        rev_left_r <= rev_left_r - dtp_pkg::CNT_W'(1);
                        if (rev_left_r == dtp_pkg::CNT_W'(1)) begin
                            if (cycles_r + dtp_pkg::CNT_W'(1)
                                >= rep_cnt) begin
                                seq_r <= dtp_pkg::SEQ_DONE;
                            end else begin
                                cycles_r <= cycles_r + dtp_pkg::CNT_W'(1);
                                seq_r    <= dtp_pkg::SEQ_IDLE;
                            end
                        end
                    end
                end
                dtp_pkg::SEQ_DONE: begin
                    seq_r <= dtp_pkg::SEQ_DONE;
                end
            endcase
        end
    end

    // Hit to pin in two cycles, far inside the latency budget
    dtp_pulse_timer u_pulse (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .fire      (fwd_hit || rev_hit),
        .width_cyc (width_cyc),
        .active    (step_pulse)
    );

    // Output side
    generate
        for (genvar p = 0; p < 2; p++) begin : g_out
            logic act;
            logic owns_step;
            assign owns_step = step_mode[p] &&
                             (p == 0 || !step_mode[0]);
            always_comb begin
                act = 1'b0;
                drive[p].oe = 1'b1;
                unique case (mode[p])
                    dtp_pkg::DTP_DIG_OUT:
                        act = regs_r[dtp_pkg::OFF_DOUT[5:2]][p];
                    dtp_pkg::DTP_OUT_MOVE:  act = in_motion;
                    dtp_pkg::DTP_OUT_MAXV:  act = at_max_vel;
                    dtp_pkg::DTP_STEP_FWD,
                    dtp_pkg::DTP_STEP_REV,
                    dtp_pkg::DTP_STEP_BOTH:
                        act = owns_step && step_pulse;
                    default: drive[p].oe = 1'b0;
                endcase
                // Undriven pins sit low; oe tells the outside
                drive[p].o = drive[p].oe && (act ~^ pol_high[p]);
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_port_a_out <= 1'b0;
            event_port_a_oe  <= 1'b0;
            event_port_b_out <= 1'b0;
            event_port_b_oe  <= 1'b0;
        end else begin
            event_port_a_out <= drive[0].o;
            event_port_a_oe  <= drive[0].oe;
            event_port_b_out <= drive[1].o;
            event_port_b_oe  <= drive[1].oe;
        end
    end

    // Status
    always_comb begin
        status = '0;
        status[dtp_pkg::STAT_LVL_A]    = pin_sync[0];
        status[dtp_pkg::STAT_LVL_B]    = pin_sync[1];
        status[dtp_pkg::STAT_BUSY]     = (seq_r == SEQ_FWD_C) ||
                                         (seq_r == SEQ_REV_C);
        status[dtp_pkg::STAT_CONFLICT] = step_mode[0] && step_mode[1];
    end

endmodule // dtp_trigger_ports

// *** sim/dtp_ext_equip.sv ***
// External equipment on trigger port a, with the port's weak pull-up
`timescale 1ns/1ps
module dtp_ext_equip (
    // Equipment drive
    input  wire logic drv_en,
    input  wire logic drv_lvl,
    // Device pin drive
    input  wire logic out,
    input  wire logic oe,
    // Resolved pin
    output logic      pin
);
    // Released line floats up to the pull-up level
    assign pin = oe ? out : (drv_en ? drv_lvl : 1'b1);
endmodule // dtp_ext_equip

// *** sim/dtp_assertions.sv ***
// Port checks for the dual trigger ports
`timescale 1ns/1ps
module dtp_chk (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    // Pins
    input wire logic        event_port_a_out,
    input wire logic        event_port_a_oe,
    input wire logic        event_port_b_out,
    input wire logic        event_port_b_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_ar; arvalid && arready; endsequence
    sequence s_wr; awvalid && awready && wvalid && wready; endsequence
    AST_R_ANS: assert property (s_ar |=> rvalid)
        else $error("read not answered");
    AST_R_HOLD: assert property (rvalid && !rready |=>
        rvalid && $stable(rdata))
        else $error("read data dropped");
    AST_AR_BLK: assert property (rvalid |-> !arready)
        else $error("read address taken early");
    AST_R_CAUSE: assert property ($rose(rvalid) |->
        $past(arvalid && arready))
        else $error("read answer without request");
    AST_B_ANS: assert property (s_wr |-> ##[1:2] bvalid)
        else $error("write not answered");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid)
        else $error("write answer dropped");
    AST_OE_A: assert property (!event_port_a_oe |-> !event_port_a_out)
        else $error("port a drive while released");
    AST_OE_B: assert property (!event_port_b_oe |-> !event_port_b_out)
        else $error("port b drive while released");
endmodule // dtp_chk
bind dtp_trigger_ports dtp_chk dtp_chk_inst (.aclk, .aresetn, .awvalid,
    .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready,
    .rvalid, .rready, .rdata, .event_port_a_out, .event_port_a_oe,
    .event_port_b_out, .event_port_b_oe);

// *** sim/dtp_trigger_ports_tb.sv ***
// Register-level bench for the dual trigger ports
`timescale 1ns/1ps
module dtp_trigger_ports_tb;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, drv_en = 0, drv_lvl = 0;
    logic in_motion = 0, at_max_vel = 0, awready, wready, bvalid;
    logic arready, rvalid, pa, pa_o, pa_oe, pb_o, pb_oe;
    logic [5:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, act_pos = 0, rel_distance, abs_target, rdata, rd;
    logic [1:0] bresp, rresp;
    dtp_pkg::dtp_move_cmd_t move_cmd, last_cmd;
    int fails = 0, comparisons = 0, cyc = 0, cmdn = 0;
    always #2.5 aclk = ~aclk;
    dtp_trigger_ports dtp_trigger_ports_inst (.aclk, .aresetn, .awaddr,
        .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .event_port_a_in(pa),
        .event_port_a_out(pa_o), .event_port_a_oe(pa_oe),
        .event_port_b_in(pb_oe ? pb_o : 1'b1), .event_port_b_out(pb_o),
        .event_port_b_oe(pb_oe), .act_pos, .in_motion, .at_max_vel,
        .move_cmd, .rel_distance, .abs_target);
    dtp_ext_equip dtp_ext_equip_inst (.drv_en, .drv_lvl, .out(pa_o),
        .oe(pa_oe), .pin(pa));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic stop_test();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bit pa_w = 1, pw = 1;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (pa_w && awready) begin awvalid <= 0; pa_w = 0; end
            if (pw && wready) begin wvalid <= 0; pw = 0; end
        end while (pa_w || pw);
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 0;
        @(posedge aclk);
    endtask
    task automatic rdr(input logic [5:0] a);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        rready <= 0;
        @(posedge aclk);
    endtask
    // Long hold shows a sustained level starts nothing more
    task automatic trig();
        drv_en <= 1; drv_lvl <= 0; repeat (8) @(posedge aclk);
        drv_lvl <= 1; repeat (20) @(posedge aclk);
        drv_lvl <= 0; repeat (8) @(posedge aclk);
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (aresetn && move_cmd != 3'h0) begin
            cmdn     <= cmdn + 1;
            last_cmd <= move_cmd;
        end
        if (cyc == 20000) begin fails++; stop_test(); end
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rdr(dtp_pkg::OFF_CTRL_A); chk(rd, 32'h10);
        rdr(6'h38); chk(rresp, dtp_pkg::RESP_SLVERR);
        wr(dtp_pkg::OFF_REL_DIST, 32'h1234);
        chk(rel_distance, 32'h1234);
        wr(dtp_pkg::OFF_ABS_POS, 32'h55);
        chk(abs_target, 32'h55);
        for (int m = 2; m < 5; m++) begin
            wr(dtp_pkg::OFF_CTRL_A, 32'h10 | m); trig();
            chk(cmdn, m - 1);
            chk(last_cmd, 3'h4 >> (m - 2));
        end
        // Polarity flips only while disabled, so no false edge
        wr(dtp_pkg::OFF_CTRL_A, 32'h0); drv_lvl <= 1;
        wr(dtp_pkg::OFF_CTRL_A, 32'h02); trig(); chk(cmdn, 5);
        wr(dtp_pkg::OFF_CTRL_A, 32'h11); trig(); chk(cmdn, 5);
        rdr(dtp_pkg::OFF_STATUS); chk(rd, 32'h2);
        wr(dtp_pkg::OFF_CTRL_A, 32'h10); trig(); chk({cmdn, pa_oe}, 10);
        wr(dtp_pkg::OFF_CTRL_A, 32'h06); in_motion <= 1; repeat (3) @(posedge aclk);
        chk({pa_oe, pa_o}, 2'b10);
        in_motion <= 0; repeat (3) @(posedge aclk); chk({pa_oe, pa_o}, 2'b11);
        wr(dtp_pkg::OFF_DOUT, 32'h1); wr(dtp_pkg::OFF_CTRL_A, 32'h15);
        chk({pa_oe, pa_o}, 2'b11);
        wr(dtp_pkg::OFF_CTRL_A, 32'h17); chk({pa_oe, pa_o}, 2'b10);
        wr(dtp_pkg::OFF_FWD_FIRST, 32'h8);
        wr(dtp_pkg::OFF_CTRL_A, 32'h18);
        act_pos <= 32'h10;
        repeat (3) @(posedge aclk);
        chk({pa_oe, pa_o}, 2'b11);
        repeat (201) @(posedge aclk);
        chk({pa_oe, pa_o}, 2'b10);
        stop_test();
    end
endmodule // dtp_trigger_ports_tb
